// [bench/pllf_host.sv]
// Host controller model driving the three-wire programming port
`timescale 1ns/1ps
module pllf_host (
	input wire logic core_clk_in,
	output logic sclk_out,
	output logic sdata_out,
	output logic load_strobe_out
);
	// Idle port: clock and strobe low, data at a level
	initial
	begin
		sclk_out = 1'h0;
		sdata_out = 1'h0;
		load_strobe_out = 1'h0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Shift a whole word MSB first at 400 ns per bit, then raise the strobe
	task automatic send_word(input logic [23:0] w);
		@(posedge core_clk_in);
		for (int i = 23; i >= 0; i--)
		begin
			sdata_out <= w[i];
			sclk_out <= 1'h0;
			repeat (4) @(posedge core_clk_in);
			sclk_out <= 1'h1;
			repeat (4) @(posedge core_clk_in);
		end
		// Clock stands still; released data shows the inverse of its last bit
		sclk_out <= 1'h0;
		sdata_out <= ~w[0];
		repeat (4) @(posedge core_clk_in);
		load_strobe_out <= 1'h1;
		repeat (4) @(posedge core_clk_in);
		load_strobe_out <= 1'h0;
		repeat (4) @(posedge core_clk_in);
	endtask
endmodule

// [bench/test_pllf_ctrl.sv]
// Self-checking bench for the function latch control
`timescale 1ns/1ps
module test_pllf_ctrl;
	logic core_clk_in;
	logic rst_in;
	logic chip_en_in;
	logic pfd_cycle_in;
	logic pump_event_in;
	logic lock_detect_in;
	logic n_div_in;
	logic r_div_in;
	logic sclk, sdata, load;
	logic pfd_sense_out, pump_float_out, boost_request_flag_out, counter_reset_out;
	logic reset_pulse_out, powerdown_out, lock_reset_out, monitor_pin_out, monitor_pin_oe_out;
	logic [2:0] pump_current_out;
	int miscompares = 0;
	int checked = 0;
	int pulses = 0;
	int cycles = 0;

	pllf_host host (.core_clk_in(core_clk_in), .sclk_out(sclk), .sdata_out(sdata),
		.load_strobe_out(load));

	pllf_ctrl dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .sclk_in(sclk), .sdata_in(sdata),
		.load_strobe_in(load), .chip_en_in(chip_en_in), .pfd_cycle_in(pfd_cycle_in),
		.pump_event_in(pump_event_in), .lock_detect_in(lock_detect_in), .n_div_in(n_div_in),
		.r_div_in(r_div_in), .pfd_sense_out(pfd_sense_out), .pump_float_out(pump_float_out),
		.pump_current_out(pump_current_out), .boost_request_flag_out(boost_request_flag_out),
		.counter_reset_out(counter_reset_out), .reset_pulse_out(reset_pulse_out),
		.powerdown_out(powerdown_out), .lock_reset_out(lock_reset_out),
		.monitor_pin_out(monitor_pin_out), .monitor_pin_oe_out(monitor_pin_oe_out));

	// 20 MHz core clock
	initial
	begin
		core_clk_in = 1'h0;
		forever #25 core_clk_in = ~core_clk_in;
	end

	// Count counter reset pulses and cut a hang short
	always @(posedge core_clk_in)
	begin
		if (reset_pulse_out === 1'h1)
			pulses++;
		cycles++;
		if (cycles == 30000)
		begin
			miscompares++;
			tally_and_finish();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk3(input logic [2:0] got, input logic [2:0] exp);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk(input logic got, input logic exp);
		chk3({2'h0, got}, {2'h0, exp});
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge core_clk_in);
	endtask

	task automatic pulse_pfd(input int n);
		repeat (n)
		begin
			pfd_cycle_in <= 1'h1;
			wait_cyc(4);
			pfd_cycle_in <= 1'h0;
			wait_cyc(4);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Reset values, read at the last reset edge where they cannot change
	task automatic test_reset();
		chk(pump_float_out, 1'h1);
		chk(counter_reset_out, 1'h1);
		chk(boost_request_flag_out, 1'h0);
		chk(monitor_pin_oe_out, 1'h0);
		chk(powerdown_out, 1'h0);
		chk(reset_pulse_out, 1'h0);
		chk3(pump_current_out, 3'h0);
	endtask

	// Function latch decode, one to four fields checked per word
	task automatic test_settings();
		host.send_word(24'hCE8082);
		chk(pfd_sense_out, 1'h1);
		chk(pump_float_out, 1'h0);
		chk(counter_reset_out, 1'h0);
		chk3(pump_current_out, 3'h5);
		host.send_word(24'h0E8102);
		chk(pfd_sense_out, 1'h0);
		chk(pump_float_out, 1'h1);
		chk(counter_reset_out, 1'h0);
		host.send_word(24'h000006);
		chk(counter_reset_out, 1'h1);
		host.send_word(24'h000081);
		chk(pfd_sense_out, 1'h0);
	endtask

	// Every monitor selection under two opposite patterns of the source pins
	task automatic test_monitor();
		logic [7:0] oe_exp;
		logic [7:0] val_exp;
		for (int p = 0; p < 2; p++)
		begin
			lock_detect_in <= p[0];
			n_div_in <= ~p[0];
			r_div_in <= p[0];
			oe_exp = p[0] ? 8'hDE : 8'hFE;
			val_exp = p[0] ? 8'h5A : 8'h4C;
			for (int m = 0; m < 8; m++)
			begin
				host.send_word(((m == 6) ? 24'h800002 : 24'h000002) | (24'(m) << 4));
				chk(monitor_pin_oe_out, oe_exp[m]);
				if (m != 0)
					chk(monitor_pin_out, val_exp[m]);
			end
		end
	endtask

	// Initialization pulses, first N load only, and sync power-down by the pulse
	task automatic test_init();
		int p0;
		p0 = pulses;
		host.send_word(24'h000003);
		chk3(3'(pulses - p0), 3'h1);
		host.send_word(24'h000001);
		host.send_word(24'h000001);
		chk3(3'(pulses - p0), 3'h2);
		host.send_word(24'h20000B);
		chk(powerdown_out, 1'h1);
		host.send_word(24'h000002);
		chk(powerdown_out, 1'h0);
	endtask

	// Async and sync programmed power-down, then the chip-enable pin
	task automatic test_powerdown();
		host.send_word(24'h00000A);
		chk(powerdown_out, 1'h1);
		chk(lock_reset_out, 1'h1);
		chk(pump_float_out, 1'h1);
		host.send_word(24'h00008A);
		chk(pfd_sense_out, 1'h1);
		host.send_word(24'h000002);
		host.send_word(24'h20000A);
		wait_cyc(20);
		chk(powerdown_out, 1'h0);
		pump_event_in <= 1'h1;
		wait_cyc(6);
		pump_event_in <= 1'h0;
		chk(powerdown_out, 1'h1);
		host.send_word(24'h000002);
		chk(powerdown_out, 1'h0);
		chip_en_in <= 1'h0;
		wait_cyc(6);
		chk(powerdown_out, 1'h1);
		chk(pump_float_out, 1'h1);
		chip_en_in <= 1'h1;
		wait_cyc(6);
		chk(powerdown_out, 1'h0);
	endtask

	// Mode 2 timeout at the shortest and longest codes
	task automatic test_mode2(input logic [3:0] c);
		int n;
		n = 3 + 4 * int'(c);
		host.send_word(24'h190602 | (24'(c) << 11));
		host.send_word(24'h200001);
		chk(boost_request_flag_out, 1'h1);
		chk3(pump_current_out, 3'h6);
		pulse_pfd(n - 1);
		chk(boost_request_flag_out, 1'h1);
		pulse_pfd(1);
		chk(boost_request_flag_out, 1'h0);
		chk3(pump_current_out, 3'h2);
	endtask

	// Mode 1 holds boost until the host clears it; disabled fastlock stays steady
	task automatic test_mode1();
		host.send_word(24'h190202);
		host.send_word(24'h200001);
		pulse_pfd(10);
		chk(boost_request_flag_out, 1'h1);
		chk3(pump_current_out, 3'h6);
		host.send_word(24'h000001);
		chk3(pump_current_out, 3'h2);
		host.send_word(24'h190002);
		host.send_word(24'h200001);
		chk3(pump_current_out, 3'h2);
		host.send_word(24'h000001);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		rst_in <= 1'h1;
		chip_en_in <= 1'h1;
		pfd_cycle_in <= 1'h0;
		pump_event_in <= 1'h0;
		lock_detect_in <= 1'h0;
		n_div_in <= 1'h1;
		r_div_in <= 1'h1;
		wait_cyc(2);
		rst_in <= 1'h0;
		test_reset();
		wait_cyc(2);
		test_settings();
		test_monitor();
		test_init();
		test_powerdown();
		test_mode2(4'h0);
		test_mode2(4'hF);
		test_mode1();
		tally_and_finish();
	end
endmodule

// [design/pllf_ctrl.sv]
// Function and initialization latch control with fastlock timer and power-down
`timescale 1ns/1ps
module pllf_ctrl (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic sclk_in,
	input wire logic sdata_in,
	input wire logic load_strobe_in,
	input wire logic chip_en_in,
	input wire logic pfd_cycle_in,
	input wire logic pump_event_in,
	input wire logic lock_detect_in,
	input wire logic n_div_in,
	input wire logic r_div_in,
	output logic pfd_sense_out,
	output logic pump_float_out,
	output logic [2:0] pump_current_out,
	output logic boost_request_flag_out,
	output logic counter_reset_out,
	output logic reset_pulse_out,
	output logic powerdown_out,
	output logic lock_reset_out,
	output logic monitor_pin_out,
	output logic monitor_pin_oe_out
);
	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisation and edge detection
	pllf_pkg::pllf_pins_s pins_raw;
	pllf_pkg::pllf_pins_s pins_q;
	logic sclk_prev_reg;
	logic load_prev_reg;
	logic pfd_prev_reg;
	logic pump_prev_reg;
	logic sclk_rise;
	logic load_rise;
	logic pfd_rise;
	logic pump_rise;

	// Pin group into the synchroniser
	assign pins_raw = '{sclk: sclk_in, sdata: sdata_in, load: load_strobe_in,
		chip_en: chip_en_in, pfd_evt: pfd_cycle_in, cp_evt: pump_event_in,
		lock: lock_detect_in, ndiv: n_div_in, rdiv: r_div_in};

	pllf_sync #(
		.W($bits(pllf_pkg::pllf_pins_s))
	) u_sync (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.d_in(pins_raw),
		.q_out(pins_q)
	);

	// Previous values for edge finding
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			sclk_prev_reg <= 1'b0;
			load_prev_reg <= 1'b0;
			pfd_prev_reg <= 1'b0;
			pump_prev_reg <= 1'b0;
		end
		else
		begin
			sclk_prev_reg <= pins_q.sclk;
			load_prev_reg <= pins_q.load;
			pfd_prev_reg <= pins_q.pfd_evt;
			pump_prev_reg <= pins_q.cp_evt;
		end
	end

	// Rising edges
	assign sclk_rise = pins_q.sclk & ~sclk_prev_reg;
	assign load_rise = pins_q.load & ~load_prev_reg;
	assign pfd_rise = pins_q.pfd_evt & ~pfd_prev_reg;
	assign pump_rise = pins_q.cp_evt & ~pump_prev_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Serial input register and latch transfer
	logic [23:0] shift_reg;
	logic [23:0] func_word_reg;
	pllf_pkg::pllf_func_s func;
	logic [1:0] sel;
	logic func_load;
	logic init_load;
	logic n_load;

	// Shift on serial clock rise, keeps running in power-down
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			shift_reg <= 24'h000000;
		else if (sclk_rise)
			shift_reg <= {shift_reg[22:0], pins_q.sdata};
	end

	// Latch select decode on strobe rise
	assign sel = shift_reg[pllf_pkg::SEL_LSB +: 2];
	assign func_load = load_rise && (sel == pllf_pkg::SEL_FUNC_LATCH);
	assign init_load = load_rise && (sel == pllf_pkg::SEL_INIT_LATCH);
	assign n_load = load_rise && (sel == pllf_pkg::SEL_N_LATCH);

	// Settings latch, written by function and initialization loads
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			func_word_reg <= pllf_pkg::FUNC_RESET;
		else if (func_load || init_load)
			func_word_reg <= shift_reg;
	end

	assign func = pllf_pkg::pllf_decode(func_word_reg);

	////////////////////////////////////////////////////////////////////////////////
	// Internal counter reset pulse
	logic n_rearm_reg;

	// Arm on initialization, consumed by the first N load after it
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			n_rearm_reg <= 1'b0;
		else if (init_load)
			n_rearm_reg <= 1'b1;
		else if (n_load)
			n_rearm_reg <= 1'b0;
	end

	// One-cycle pulse on initialization or armed N load
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			reset_pulse_out <= 1'b0;
		else
			reset_pulse_out <= init_load || (n_load && n_rearm_reg);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Power-down control
	pllf_pkg::pllf_pd_e pd_state_reg;
	pllf_pkg::pllf_pd_e pd_state_next;

	// Next power-down state
	always_comb
	begin
		pd_state_next = pd_state_reg;
		if (!pins_q.chip_en)
			pd_state_next = pllf_pkg::PD_DOWN;
		else if (!func.pd_request)
			pd_state_next = pllf_pkg::PD_RUN;
		else if (!func.sync_select)
			pd_state_next = pllf_pkg::PD_DOWN;
		else
		begin
			case (pd_state_reg)
				pllf_pkg::PD_RUN,
				pllf_pkg::PD_WAIT:
				begin
					if (pump_rise || reset_pulse_out)
						pd_state_next = pllf_pkg::PD_DOWN;
					else
						pd_state_next = pllf_pkg::PD_WAIT;
				end
				pllf_pkg::PD_DOWN:
					pd_state_next = pllf_pkg::PD_DOWN;
				default:
					pd_state_next = pllf_pkg::PD_RUN;
			endcase
		end
	end

	// Power-down state register
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			pd_state_reg <= pllf_pkg::PD_RUN;
		else
			pd_state_reg <= pd_state_next;
	end

	assign powerdown_out = (pd_state_reg == pllf_pkg::PD_DOWN);
	assign lock_reset_out = powerdown_out;

	////////////////////////////////////////////////////////////////////////////////
	// Fastlock boost request and timeout counter
	logic boost_flag_reg;
	logic [5:0] tmo_count_reg;
	logic mode2;
	logic expire;

	// Timeout limit less one
	function automatic logic [5:0] pllf_timeout_m1(input logic [3:0] code);
		return 6'(pllf_pkg::pllf_timeout(code) - 6'h01);
	endfunction

	assign mode2 = func.boost_enable && func.boost_variant;
	assign expire = mode2 && boost_flag_reg && pfd_rise && !powerdown_out
		&& (tmo_count_reg == 6'(pllf_timeout_m1(func.timeout_code)));

	// Boost request, an N load write wins over the timeout clear
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			boost_flag_reg <= 1'b0;
		else if (n_load)
			boost_flag_reg <= shift_reg[pllf_pkg::POS_BOOST_REQUEST];
		else if (expire)
			boost_flag_reg <= 1'b0;
	end

	// Counts phase comparator cycles only in mode 2
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in || !mode2 || powerdown_out || n_load || expire)
			tmo_count_reg <= 6'h00;
		else if (boost_flag_reg && pfd_rise)
			tmo_count_reg <= 6'(tmo_count_reg + 6'h01);
	end

	assign boost_request_flag_out = boost_flag_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Charge pump and counter control outputs
	// Registered pump and counter controls
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			pfd_sense_out <= 1'b0;
			pump_float_out <= 1'b1;
			pump_current_out <= 3'h0;
			counter_reset_out <= 1'b1;
		end
		else
		begin
			pfd_sense_out <= func.pfd_sense;
			pump_float_out <= func.pump_float || powerdown_out || func.counter_hold
				|| reset_pulse_out;
			if (func.boost_enable && boost_flag_reg)
				pump_current_out <= func.boost_code;
			else
				pump_current_out <= func.steady_code;
			counter_reset_out <= func.counter_hold || powerdown_out
				|| reset_pulse_out;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Monitor pin
	// Routes the selected source, open-drain lock drives only low
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			monitor_pin_out <= 1'b0;
			monitor_pin_oe_out <= 1'b0;
		end
		else
		begin
			monitor_pin_oe_out <= 1'b1;
			monitor_pin_out <= 1'b0;
			case (func.monitor_sel)
				pllf_pkg::MON_FLOAT: monitor_pin_oe_out <= 1'b0;
				pllf_pkg::MON_LOCK: monitor_pin_out <= pins_q.lock;
				pllf_pkg::MON_NDIV: monitor_pin_out <= pins_q.ndiv;
				pllf_pkg::MON_HIGH: monitor_pin_out <= 1'b1;
				pllf_pkg::MON_RDIV: monitor_pin_out <= pins_q.rdiv;
				pllf_pkg::MON_LOCK_OD: monitor_pin_oe_out <= ~pins_q.lock;
				pllf_pkg::MON_SERIAL: monitor_pin_out <= shift_reg[23];
				pllf_pkg::MON_LOW: monitor_pin_out <= 1'b0;
				default: monitor_pin_oe_out <= 1'b0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);

	chk_ce_low_down: assert property (!pins_q.chip_en |=> powerdown_out)
		else $error("chip enable low did not power down");
	chk_async_pd_now: assert property (pins_q.chip_en && func.pd_request
		&& !func.sync_select |=> powerdown_out)
		else $error("asynchronous power-down not taken");
	chk_sync_pd_wait: assert property (pd_state_reg == pllf_pkg::PD_RUN && pins_q.chip_en
		&& func.pd_request && func.sync_select && !pump_rise && !reset_pulse_out
		|=> !powerdown_out)
		else $error("synchronous power-down did not wait");
	chk_init_pulse_pd: assert property (pd_state_reg != pllf_pkg::PD_DOWN && pins_q.chip_en
		&& func.pd_request && func.sync_select && reset_pulse_out |=> powerdown_out)
		else $error("reset pulse did not trigger power-down");
	chk_init_pulse_one: assert property (init_load |=> reset_pulse_out
		##1 (!reset_pulse_out || $past(init_load || n_load)))
		else $error("initialization pulse wrong");
	chk_n_pulse_once: assert property (n_load && !n_rearm_reg && !init_load
		|=> !reset_pulse_out)
		else $error("unarmed N load pulsed reset");
	chk_n_pulse_armed: assert property (n_load && n_rearm_reg |=> reset_pulse_out)
		else $error("first N load after init missed pulse");
	chk_counter_hold: assert property (func.counter_hold |=> counter_reset_out)
		else $error("counter hold not applied");
	chk_pd_float: assert property (powerdown_out |=> pump_float_out && counter_reset_out
		&& (tmo_count_reg == 6'h00))
		else $error("power-down did not float pump and clear counters");
	chk_tmo_idle: assert property (!mode2 |=> tmo_count_reg == 6'h00)
		else $error("timeout counter ran outside mode 2");
	chk_boost_current: assert property (func.boost_enable && boost_flag_reg
		|=> pump_current_out == $past(func.boost_code))
		else $error("boost current not selected");
	chk_tmo_clear: assert property (expire && !n_load |=> !boost_flag_reg)
		else $error("timeout did not clear boost request");
	chk_mon_float: assert property (func.monitor_sel == pllf_pkg::MON_FLOAT
		|=> !monitor_pin_oe_out)
		else $error("monitor pin driven while floating");
endmodule

// [design/pllf_pkg.sv]
// Package with field layout, latch codes and types of the PLL function latch control
package pllf_pkg;
	// Word and latch select layout
	localparam int WORD_W = 24;
	localparam int SEL_LSB = 0;
	localparam logic [1:0] SEL_R_LATCH = 2'h0;
	localparam logic [1:0] SEL_N_LATCH = 2'h1;
	localparam logic [1:0] SEL_FUNC_LATCH = 2'h2;
	localparam logic [1:0] SEL_INIT_LATCH = 2'h3;
	// Function word field positions
	localparam int POS_COUNTER_HOLD = 2;
	localparam int POS_PD_REQUEST = 3;
	localparam int POS_MONITOR_SEL = 4;
	localparam int POS_PFD_SENSE = 7;
	localparam int POS_PUMP_FLOAT = 8;
	localparam int POS_BOOST_ENABLE = 9;
	localparam int POS_BOOST_VARIANT = 10;
	localparam int POS_TIMEOUT = 11;
	localparam int POS_STEADY_CODE = 15;
	localparam int POS_BOOST_CODE = 18;
	localparam int POS_SYNC_SELECT = 21;
	// N counter word boost request position
	localparam int POS_BOOST_REQUEST = 21;
	// Reset value of the settings latch
	localparam logic [23:0] FUNC_RESET = 24'h000000;
	// Timeout in phase comparator cycles is base plus step times code
	localparam logic [5:0] TIMEOUT_BASE = 6'h03;
	localparam logic [5:0] TIMEOUT_STEP = 6'h04;

	// Monitor pin selections
	typedef enum logic [2:0] {
		MON_FLOAT = 3'h0,
		MON_LOCK = 3'h1,
		MON_NDIV = 3'h2,
		MON_HIGH = 3'h3,
		MON_RDIV = 3'h4,
		MON_LOCK_OD = 3'h5,
		MON_SERIAL = 3'h6,
		MON_LOW = 3'h7
	} pllf_mon_e;

	// Power-down state
	typedef enum logic [1:0] {
		PD_RUN = 2'h0,
		PD_WAIT = 2'h1,
		PD_DOWN = 2'h2
	} pllf_pd_e;

	// Decoded settings word
	typedef struct packed {
		logic sync_select;
		logic [2:0] boost_code;
		logic [2:0] steady_code;
		logic [3:0] timeout_code;
		logic boost_variant;
		logic boost_enable;
		logic pump_float;
		logic pfd_sense;
		pllf_mon_e monitor_sel;
		logic pd_request;
		logic counter_hold;
	} pllf_func_s;

	// Outside pins grouped for synchronising
	typedef struct packed {
		logic sclk;
		logic sdata;
		logic load;
		logic chip_en;
		logic pfd_evt;
		logic cp_evt;
		logic lock;
		logic ndiv;
		logic rdiv;
	} pllf_pins_s;

	// Split a 24-bit word into the settings fields
	function automatic pllf_func_s pllf_decode(input logic [23:0] w);
		pllf_func_s f;
		f.sync_select = w[POS_SYNC_SELECT];
		f.boost_code = w[POS_BOOST_CODE +: 3];
		f.steady_code = w[POS_STEADY_CODE +: 3];
		f.timeout_code = w[POS_TIMEOUT +: 4];
		f.boost_variant = w[POS_BOOST_VARIANT];
		f.boost_enable = w[POS_BOOST_ENABLE];
		f.pump_float = w[POS_PUMP_FLOAT];
		f.pfd_sense = w[POS_PFD_SENSE];
		f.monitor_sel = pllf_mon_e'(w[POS_MONITOR_SEL +: 3]);
		f.pd_request = w[POS_PD_REQUEST];
		f.counter_hold = w[POS_COUNTER_HOLD];
		return f;
	endfunction

	// Fastlock duration in phase comparator cycles
	function automatic logic [5:0] pllf_timeout(input logic [3:0] code);
		return 6'(TIMEOUT_BASE + TIMEOUT_STEP * {2'h0, code});
	endfunction
endpackage

// [design/pllf_sync.sv]
// Two-flop synchroniser for a group of outside levels
`timescale 1ns/1ps
module pllf_sync #(
	parameter int W = 9
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] meta_reg;

	// First stage feeds only the second stage
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			meta_reg <= '0;
			q_out <= '0;
		end
		else
		begin
			meta_reg <= d_in;
			q_out <= meta_reg;
		end
	end
endmodule
